// [design/sc_base_clk.sv]
// Base clock tick: main clock divided by 2^m or external clock edges
`timescale 1ns/1ps
`default_nettype none
`include "sc_map.svh"
module sc_base_clk #(
   parameter int PRESCALE_W = 10
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic power_enable_bit,
   input wire logic [3:0] clock_select_field,
   input wire logic ext_clk_pin,
   output logic base_tick
);
   if (PRESCALE_W != 10)
   begin : g_bad
      $error("sc_base_clk: PRESCALE_W must be 10");
   end
   logic [PRESCALE_W-1:0] pre_cnt;
   logic ext_s1;
   logic ext_s2;
   logic ext_s3;
   wire [PRESCALE_W-1:0] sel_mask = PRESCALE_W'((11'h001 << clock_select_field) - 11'h001);
   wire int_tick = (pre_cnt & sel_mask) == sel_mask;
   wire ext_tick = ext_s2 & ~ext_s3;
   wire next_tick = power_enable_bit &&
      ((clock_select_field == `SC_CKS_EXT) ? ext_tick : int_tick);
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pre_cnt <= '0;
         ext_s1 <= 1'b0;
         ext_s2 <= 1'b0;
         ext_s3 <= 1'b0;
         base_tick <= 1'b0;
      end
      else
      begin
         // Counter only runs while powered
         pre_cnt <= power_enable_bit ? pre_cnt + 1'b1 : '0;
         ext_s1 <= ext_clk_pin;
         ext_s2 <= ext_s1;
         ext_s3 <= ext_s2;
         base_tick <= next_tick;
      end
   end
endmodule
`default_nettype wire

// [design/sc_core.sv]
// Serial channel: transmitter, receiver, error flags and baud counters
`timescale 1ns/1ps
`default_nettype none
`include "sc_map.svh"
module sc_core #(
   parameter int DATA_BITS = 8,
   parameter int PRESCALE_W = 10
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire sc_pkg::sc_cfg_t cfg,
   input wire logic ext_clk_pin,
   input wire logic rx_line,
   input wire logic tx_write,
   input wire logic [7:0] tx_wdata,
   input wire logic rx_read,
   input wire logic status_write,
   input wire logic [2:0] status_wdata,
   output logic tx_line,
   output logic tx_enable_irq,
   output logic rx_complete_irq,
   output logic [7:0] rx_buffer,
   output sc_pkg::sc_status_t serial_status_reg
);
   if (DATA_BITS != 8)
   begin : g_bad
      $error("sc_core: DATA_BITS must be 8");
   end

   typedef enum logic [1:0] {
      SC_TX_IDLE = 2'b01,
      SC_TX_SHIFT = 2'b10
   } sc_tx_state_t;
   typedef enum logic [2:0] {
      SC_RX_IDLE = 3'b001,
      SC_RX_START = 3'b010,
      SC_RX_DATA = 3'b100
   } sc_rx_state_t;

   logic base_tick;
   logic rx_filt;
   logic rx_filt_d;
   sc_tx_state_t tx_state;
   sc_rx_state_t rx_state;
   logic [7:0] tx_buffer;
   logic tx_buf_full;
   logic [9:0] tx_sh;
   logic [3:0] tx_left;
   logic [7:0] tx_cnt;
   logic tx_half;
   logic tx_busy;
   logic [8:0] rx_sh;
   logic [3:0] rx_left;
   logic [7:0] rx_cnt;
   logic rx_half;
   logic rx_full;
   logic [2:0] err_flag;

   sc_base_clk #(
      .PRESCALE_W(PRESCALE_W)
   ) u_base (
      .core_clk(core_clk),
      .resetn(resetn),
      .power_enable_bit(cfg.power_enable_bit),
      .clock_select_field(cfg.clock_select_field),
      .ext_clk_pin(ext_clk_pin),
      .base_tick(base_tick)
   );

   sc_rx_filter u_filt (
      .core_clk(core_clk),
      .resetn(resetn),
      .base_tick(base_tick),
      .rx_line(rx_line),
      .rx_filt(rx_filt)
   );

   // Configuration decode
   wire sc_pkg::sc_parity_t pmode = cfg.parity_select;
   wire par_used = pmode != sc_pkg::SC_PAR_NONE;
   wire [7:0] k = cfg.baud_divisor_field;
   wire tx_active = cfg.power_enable_bit && cfg.tx_enable_bit;
   wire rx_active = cfg.power_enable_bit && cfg.rx_enable_bit;

   // Transmit side
   wire tx_wrap = base_tick && (tx_cnt == k - 8'h01);
   wire tx_bit_end = tx_wrap && tx_half;
   wire tx_frame_end = (tx_state == SC_TX_SHIFT) && tx_bit_end && (tx_left == 4'h0);
   wire tx_load = tx_active && tx_buf_full && ((tx_state == SC_TX_IDLE) || tx_frame_end);
   wire tx_par_even = ^tx_buffer;
   wire tx_par = (pmode == sc_pkg::SC_PAR_EVEN) ? tx_par_even
      : (pmode == sc_pkg::SC_PAR_ODD) ? ~tx_par_even : 1'b0;
   wire [9:0] tx_frame = par_used ? {1'b1, tx_par, tx_buffer}
      : {2'b11, tx_buffer};
   // Bit periods including the start bit: data, optional parity, one stop bit
   wire [3:0] tx_len = par_used ? `SC_DATA_BITS + 4'h3 : `SC_DATA_BITS + 4'h2;
   wire next_tx_busy = tx_load || ((tx_state == SC_TX_SHIFT) && !tx_frame_end && tx_active);

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         tx_cnt <= 8'h00;
         tx_half <= 1'b0;
      end
      else if (!tx_active || tx_load)
      begin
         tx_cnt <= 8'h00;
         tx_half <= 1'b0;
      end
      else if (base_tick)
      begin
         tx_cnt <= tx_wrap ? 8'h00 : tx_cnt + 8'h01;
         tx_half <= tx_wrap ? ~tx_half : tx_half;
      end
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         tx_buffer <= 8'h00;
         tx_buf_full <= 1'b0;
      end
      else if (tx_active && tx_write)
      begin
         tx_buffer <= tx_wdata;
         tx_buf_full <= 1'b1;
      end
      else if (tx_load || !tx_active)
      begin
         tx_buf_full <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         tx_state <= SC_TX_IDLE;
         tx_line <= 1'b1;
         tx_sh <= 10'h3ff;
         tx_left <= 4'h0;
      end
      else if (tx_load)
      begin
         tx_state <= SC_TX_SHIFT;
         tx_line <= 1'b0;
         tx_sh <= tx_frame;
         tx_left <= tx_len - 4'h1;
      end
      else if (!tx_active || tx_frame_end)
      begin
         tx_state <= SC_TX_IDLE;
         tx_line <= 1'b1;
      end
      else if ((tx_state == SC_TX_SHIFT) && tx_bit_end)
      begin
         tx_line <= tx_sh[0];
         tx_sh <= {1'b1, tx_sh[9:1]};
         tx_left <= tx_left - 4'h1;
      end
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         tx_enable_irq <= 1'b0;
         tx_busy <= 1'b0;
      end
      else
      begin
         tx_enable_irq <= tx_load;
         tx_busy <= next_tx_busy;
      end
   end

   // Receive side
   wire rx_fall = rx_filt_d && !rx_filt;
   wire rx_begin = (rx_state == SC_RX_IDLE) && rx_active && rx_fall;
   wire rx_wrap = base_tick && (rx_cnt == k - 8'h01);
   wire rx_samp = rx_wrap && !rx_half;
   wire rx_done = (rx_state == SC_RX_DATA) && rx_samp && (rx_left == 4'h0);
   wire [7:0] rx_data = par_used ? rx_sh[7:0] : rx_sh[8:1];
   wire rx_ones_odd = ^rx_sh;
   wire rx_pe = ((pmode == sc_pkg::SC_PAR_EVEN) && rx_ones_odd) ||
      ((pmode == sc_pkg::SC_PAR_ODD) && !rx_ones_odd);
   wire rx_fe = !rx_filt;
   wire rx_ove = rx_full;
   wire [2:0] err_set = rx_done ? {rx_ove, rx_pe, rx_fe} : 3'h0;

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rx_cnt <= 8'h00;
         rx_half <= 1'b0;
      end
      else if (rx_state == SC_RX_IDLE)
      begin
         rx_cnt <= 8'h00;
         rx_half <= 1'b0;
      end
      else if (base_tick)
      begin
         rx_cnt <= rx_wrap ? 8'h00 : rx_cnt + 8'h01;
         rx_half <= rx_wrap ? ~rx_half : rx_half;
      end
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rx_state <= SC_RX_IDLE;
         rx_filt_d <= 1'b1;
         rx_sh <= 9'h000;
         rx_left <= 4'h0;
      end
      else
      begin
         rx_filt_d <= rx_filt;
         if (!rx_active)
         begin
            rx_state <= SC_RX_IDLE;
         end
         else if (rx_begin)
         begin
            rx_state <= SC_RX_START;
         end
         else if ((rx_state == SC_RX_START) && rx_samp)
         begin
            rx_state <= rx_filt ? SC_RX_IDLE : SC_RX_DATA;
            rx_left <= par_used ? `SC_DATA_BITS + 4'h1 : `SC_DATA_BITS;
         end
         else if (rx_done)
         begin
            rx_state <= SC_RX_IDLE;
         end
         else if ((rx_state == SC_RX_DATA) && rx_samp)
         begin
            rx_sh <= {rx_filt, rx_sh[8:1]};
            rx_left <= rx_left - 4'h1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rx_buffer <= `SC_RXBUF_RST;
         rx_full <= 1'b0;
         rx_complete_irq <= 1'b0;
      end
      else
      begin
         rx_complete_irq <= rx_done;
         if (rx_done && !rx_full)
         begin
            rx_buffer <= rx_data;
         end
         // Completion wins over a read in the same cycle; overrun keeps old byte
         rx_full <= rx_done || (rx_full && !rx_read);
      end
   end

   // Sticky error flags, cleared by writing 0; a new error wins
   for (genvar i = 0; i < 3; i++)
   begin : g_err
      wire clr = status_write && !status_wdata[i];
      always_ff @(posedge core_clk or negedge resetn)
      begin
         if (!resetn)
         begin
            err_flag[i] <= 1'b0;
         end
         else
         begin
            err_flag[i] <= err_set[i] || (err_flag[i] && !clr);
         end
      end
   end

   assign serial_status_reg.tx_shift_busy_flag = tx_busy;
   assign serial_status_reg.overrun_flag = err_flag[`SC_ERR_OVE];
   assign serial_status_reg.parity_error_flag = err_flag[`SC_ERR_PE];
   assign serial_status_reg.framing_error_flag = err_flag[`SC_ERR_FE];

   // Checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);

   a_tx_load_start: assert property (tx_load |=> tx_enable_irq && tx_busy && !tx_line
      && (!tx_buf_full || $past(tx_write)))
      else $error("load did not start frame");
   a_tx_par_even: assert property (tx_load && pmode == sc_pkg::SC_PAR_EVEN |=> tx_sh[8] == ^$past(tx_buffer))
      else $error("even tx parity wrong");
   a_tx_par_odd: assert property (tx_load && pmode == sc_pkg::SC_PAR_ODD |=> tx_sh[8] != ^$past(tx_buffer))
      else $error("odd tx parity wrong");
   a_tx_busy_end: assert property (tx_frame_end && !tx_load |=> !tx_busy && tx_line)
      else $error("busy stayed after stop");
   a_rx_disabled: assert property (!rx_active |=> rx_state == SC_RX_IDLE)
      else $error("receiver active while disabled");
   a_start_reject: assert property (rx_state == SC_RX_START && rx_samp && rx_filt |=> rx_state == SC_RX_IDLE)
      else $error("false start accepted");
   a_rx_copy: assert property (rx_done && !rx_full |=> rx_complete_irq && rx_buffer == $past(rx_data))
      else $error("byte not copied");
   a_ovr_keep: assert property (rx_done && rx_full |=> $stable(rx_buffer) && serial_status_reg.overrun_flag)
      else $error("overrun overwrote buffer");
   a_fe_flag: assert property (rx_done && !rx_filt |=> serial_status_reg.framing_error_flag && rx_complete_irq)
      else $error("framing error missed");
   a_pe_even: assert property (rx_done && pmode == sc_pkg::SC_PAR_EVEN && ^rx_sh |=> serial_status_reg.parity_error_flag)
      else $error("even parity error missed");
   a_pe_odd: assert property (rx_done && pmode == sc_pkg::SC_PAR_ODD && !(^rx_sh) |=> serial_status_reg.parity_error_flag)
      else $error("odd parity error missed");
   a_pe_none: assert property (!serial_status_reg.parity_error_flag &&
      (pmode == sc_pkg::SC_PAR_NONE || pmode == sc_pkg::SC_PAR_ZERO)
      |=> !serial_status_reg.parity_error_flag)
      else $error("parity error without parity");
   a_flag_sticky: assert property (serial_status_reg.framing_error_flag && !status_write |=> serial_status_reg.framing_error_flag)
      else $error("error flag dropped");

   c_tx_back: cover property (tx_load && tx_state == SC_TX_SHIFT);
   c_rx_ok: cover property (rx_done && !rx_full && !rx_pe && !rx_fe);
   c_rx_ovr: cover property (rx_done && rx_full);
   c_start_rej: cover property (rx_state == SC_RX_START && rx_samp && rx_filt);
endmodule
`default_nettype wire

// [design/sc_map.svh]
// Constants of the serial channel: field codes, reset values, limits
`ifndef SC_MAP_SVH
`define SC_MAP_SVH
`define SC_PAR_NONE 2'h0
`define SC_PAR_ZERO 2'h1
`define SC_PAR_ODD 2'h2
`define SC_PAR_EVEN 2'h3
`define SC_CKS_EXT 4'hb
`define SC_CKS_MAX 4'ha
`define SC_BAUD_MIN 8'h04
`define SC_RXBUF_RST 8'hff
`define SC_DATA_BITS 4'h8
`define SC_ERR_FE 0
`define SC_ERR_PE 1
`define SC_ERR_OVE 2
`endif

// [design/sc_pkg.sv]
// Types shared by the serial channel modules
`include "sc_map.svh"
package sc_pkg;
   typedef enum logic [1:0] {
      SC_PAR_NONE = `SC_PAR_NONE,
      SC_PAR_ZERO = `SC_PAR_ZERO,
      SC_PAR_ODD = `SC_PAR_ODD,
      SC_PAR_EVEN = `SC_PAR_EVEN
   } sc_parity_t;
   typedef struct packed {
      logic power_enable_bit;
      logic tx_enable_bit;
      logic rx_enable_bit;
      sc_parity_t parity_select;
      logic [3:0] clock_select_field;
      logic [7:0] baud_divisor_field;
   } sc_cfg_t;
   typedef struct packed {
      logic tx_shift_busy_flag;
      logic overrun_flag;
      logic parity_error_flag;
      logic framing_error_flag;
   } sc_status_t;
endpackage

// [design/sc_rx_filter.sv]
// Receive line synchroniser and two-sample noise filter
`timescale 1ns/1ps
`default_nettype none
module sc_rx_filter (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic base_tick,
   input wire logic rx_line,
   output logic rx_filt
);
   logic rx_s1;
   logic rx_s2;
   logic rx_samp;
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rx_s1 <= 1'b1;
         rx_s2 <= 1'b1;
         rx_samp <= 1'b1;
         rx_filt <= 1'b1;
      end
      else
      begin
         rx_s1 <= rx_line;
         rx_s2 <= rx_s1;
         if (base_tick)
         begin
            rx_samp <= rx_s2;
            if (rx_samp == rx_s2)
            begin
               rx_filt <= rx_s2;
            end
         end
      end
   end
endmodule
`default_nettype wire

// [tb/sc_core_test.sv]
// Self-checking bench for the serial channel core
`timescale 1ns/1ps
`default_nettype none
module sc_core_test;
   localparam int K = 4;
   logic core_clk;
   logic resetn;
   sc_pkg::sc_cfg_t cfg;
   logic tx_write;
   logic [7:0] tx_wdata;
   logic rx_read;
   logic status_write;
   logic [2:0] status_wdata;
   logic rx_line;
   logic tx_line;
   logic tx_enable_irq;
   logic rx_complete_irq;
   logic [7:0] rx_buffer;
   sc_pkg::sc_status_t serial_status_reg;
   logic [7:0] got_data;
   logic got_par;
   logic got_stop;
   logic [7:0] got_cnt;
   logic [7:0] cnt_mark;
   int miscompares;
   int checks_done;

   sc_core u_sc_core (.core_clk(core_clk), .resetn(resetn), .cfg(cfg), .ext_clk_pin(1'b0),
      .rx_line(rx_line), .tx_write(tx_write), .tx_wdata(tx_wdata), .rx_read(rx_read),
      .status_write(status_write), .status_wdata(status_wdata), .tx_line(tx_line),
      .tx_enable_irq(tx_enable_irq), .rx_complete_irq(rx_complete_irq),
      .rx_buffer(rx_buffer), .serial_status_reg(serial_status_reg));

   sc_remote_node #(.BIT_CYC(2 * K)) u_sc_remote_node (.core_clk(core_clk), .tx_line(tx_line),
      .par_mode(cfg.parity_select), .rx_line(rx_line), .got_data(got_data),
      .got_par(got_par), .got_stop(got_stop), .got_cnt(got_cnt));

   initial
   begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   function automatic logic probe(input int sel);
      case (sel)
         0: return rx_complete_irq;
         1: return tx_enable_irq;
         2: return got_cnt != cnt_mark;
         default: return !serial_status_reg.tx_shift_busy_flag;
      endcase
   endfunction

   // Bounded wait; an unexpected outcome ends the run
   task automatic wait_for(input int sel, input int lim, input logic exp);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < lim && hit !== 1'b1; i++)
      begin
         @(negedge core_clk);
         hit = probe(sel);
      end
      check("wait", {7'h0, hit}, {7'h0, exp});
      if (hit !== exp)
         end_sim();
   endtask

   task automatic wr_byte(input logic [7:0] d);
      tx_wdata = d;
      tx_write = 1'b1;
      @(negedge core_clk);
      tx_write = 1'b0;
   endtask

   task automatic sw_read();
      rx_read = 1'b1;
      status_write = 1'b1;
      status_wdata = 3'h0;
      @(negedge core_clk);
      rx_read = 1'b0;
      status_write = 1'b0;
      status_wdata = 3'h7;
   endtask

   task automatic rx_frame(input logic [7:0] d, input logic flip, input logic stop_v,
      input logic [2:0] exp_err, input logic [7:0] exp_buf);
      fork
         u_sc_remote_node.send(d, flip, stop_v);
         wait_for(0, 150, 1'b1);
      join
      check("rx buffer", rx_buffer, exp_buf);
      check("rx errors", {5'h0, serial_status_reg[2:0]}, {5'h0, exp_err});
   endtask

   task automatic t_reset();
      check("reset out", {6'h0, tx_line, rx_complete_irq | tx_enable_irq}, 8'h02);
      check("reset buf", rx_buffer, 8'hff);
      check("reset stat", {4'h0, serial_status_reg}, 8'h00);
   endtask

   task automatic t_tx();
      logic [7:0] d;
      logic p;
      for (int m = 0; m < 4; m++)
      begin
         cfg.parity_select = sc_pkg::sc_parity_t'(m);
         d = m[0] ? 8'h31 : 8'h32;
         p = (m == 3) ? ^d : ((m == 2) ? ~^d : 1'b0);
         cnt_mark = got_cnt;
         wr_byte(d);
         check("tx irq early", {7'h0, tx_enable_irq}, 8'h00);
         @(negedge core_clk);
         check("tx start", {5'h0, tx_enable_irq, tx_line,
            serial_status_reg.tx_shift_busy_flag}, 8'h05);
         wait_for(2, 200, 1'b1);
         check("tx data", got_data, d);
         check("tx parity", {7'h0, got_par}, {7'h0, p});
         check("tx stop", {7'h0, got_stop}, 8'h01);
         wait_for(3, 2 * K, 1'b1);
      end
   endtask

   task automatic t_tx_cont();
      cfg.parity_select = sc_pkg::SC_PAR_NONE;
      cnt_mark = got_cnt;
      wr_byte(8'hc3);
      wait_for(1, 4, 1'b1);
      wr_byte(8'h5e);
      wait_for(2, 200, 1'b1);
      check("cont first", got_data, 8'hc3);
      check("cont stop", {7'h0, got_stop}, 8'h01);
      cnt_mark = got_cnt;
      wait_for(1, 2 * K, 1'b1);
      check("cont busy", {7'h0, serial_status_reg.tx_shift_busy_flag}, 8'h01);
      wait_for(2, 200, 1'b1);
      check("cont second", got_data, 8'h5e);
      wait_for(3, 2 * K, 1'b1);
   endtask

   task automatic t_rx_modes();
      for (int m = 0; m < 4; m++)
      begin
         cfg.parity_select = sc_pkg::sc_parity_t'(m);
         rx_frame(8'h96 ^ 8'(m), m == 1, 1'b1, 3'h0, 8'h96 ^ 8'(m));
         sw_read();
      end
   endtask

   task automatic t_rx_err();
      cfg.parity_select = sc_pkg::SC_PAR_EVEN;
      rx_frame(8'h5a, 1'b1, 1'b1, 3'h2, 8'h5a);
      repeat (20) @(negedge core_clk);
      check("pe held", {5'h0, serial_status_reg[2:0]}, 8'h02);
      sw_read();
      check("pe cleared", {5'h0, serial_status_reg[2:0]}, 8'h00);
      cfg.parity_select = sc_pkg::SC_PAR_ODD;
      rx_frame(8'h5a, 1'b1, 1'b1, 3'h2, 8'h5a);
      sw_read();
      rx_frame(8'h3c, 1'b0, 1'b0, 3'h1, 8'h3c);
      sw_read();
   endtask

   task automatic t_overrun();
      cfg.parity_select = sc_pkg::SC_PAR_NONE;
      rx_frame(8'h11, 1'b0, 1'b1, 3'h0, 8'h11);
      rx_frame(8'h22, 1'b0, 1'b1, 3'h4, 8'h11);
      sw_read();
   endtask

   task automatic t_noise();
      fork
         u_sc_remote_node.pulse(2);
         wait_for(0, 120, 1'b0);
      join
      fork
         u_sc_remote_node.pulse(3);
         wait_for(0, 120, 1'b0);
      join
      rx_frame(8'h7e, 1'b0, 1'b1, 3'h0, 8'h7e);
      sw_read();
   endtask

   task automatic t_off();
      cfg.rx_enable_bit = 1'b0;
      fork
         u_sc_remote_node.send(8'h44, 1'b0, 1'b1);
         wait_for(0, 120, 1'b0);
      join
      cfg.rx_enable_bit = 1'b1;
      rx_frame(8'h44, 1'b0, 1'b1, 3'h0, 8'h44);
      sw_read();
      cfg.power_enable_bit = 1'b0;
      wr_byte(8'h81);
      wait_for(1, 8, 1'b0);
      check("off line", {7'h0, tx_line}, 8'h01);
   endtask

   initial
   begin
      resetn = 1'b0;
      cfg = {1'b1, 1'b1, 1'b1, sc_pkg::SC_PAR_NONE, 4'h0, 8'(K)};
      tx_write = 1'b0;
      tx_wdata = 8'h00;
      rx_read = 1'b0;
      status_write = 1'b0;
      status_wdata = 3'h7;
      cnt_mark = 8'h00;
      miscompares = 0;
      checks_done = 0;
      repeat (2) @(negedge core_clk);
      resetn = 1'b1;
      @(negedge core_clk);
      t_reset();
      t_tx();
      t_tx_cont();
      t_rx_modes();
      t_rx_err();
      t_overrun();
      t_noise();
      t_off();
      end_sim();
   end
endmodule
`default_nettype wire

// [tb/sc_remote_node.sv]
// Remote serial node: drives the receive line, decodes the transmit line
`timescale 1ns/1ps
`default_nettype none
module sc_remote_node #(
   parameter int BIT_CYC = 8
) (
   input wire logic core_clk,
   input wire logic tx_line,
   input wire sc_pkg::sc_parity_t par_mode,
   output logic rx_line,
   output logic [7:0] got_data,
   output logic got_par,
   output logic got_stop,
   output logic [7:0] got_cnt
);
   initial
   begin
      rx_line = 1'b1;
      got_data = 8'h00;
      got_par = 1'b0;
      got_stop = 1'b0;
      got_cnt = 8'h00;
   end

   task automatic put_bit(input logic b);
      rx_line = b;
      repeat (BIT_CYC) @(negedge core_clk);
   endtask

   // Frame with optional parity fault and chosen stop level, then one idle bit
   task automatic send(input logic [7:0] d, input logic flip_par, input logic stop_val);
      logic p;
      p = ^d ^ (par_mode == sc_pkg::SC_PAR_ODD) ^ flip_par;
      if (par_mode == sc_pkg::SC_PAR_ZERO)
         p = flip_par;
      put_bit(1'b0);
      for (int i = 0; i < 8; i++)
         put_bit(d[i]);
      if (par_mode != sc_pkg::SC_PAR_NONE)
         put_bit(p);
      put_bit(stop_val);
      put_bit(1'b1);
   endtask

   // Short low glitch on the line
   task automatic pulse(input int low_cyc);
      rx_line = 1'b0;
      repeat (low_cyc) @(negedge core_clk);
      rx_line = 1'b1;
   endtask

   // Mid-bit sampling of frames sent by the core
   always
   begin
      @(negedge tx_line);
      repeat (BIT_CYC / 2) @(posedge core_clk);
      for (int i = 0; i < 8; i++)
      begin
         repeat (BIT_CYC) @(posedge core_clk);
         got_data[i] = tx_line;
      end
      got_par = 1'b0;
      if (par_mode != sc_pkg::SC_PAR_NONE)
      begin
         repeat (BIT_CYC) @(posedge core_clk);
         got_par = tx_line;
      end
      repeat (BIT_CYC) @(posedge core_clk);
      got_stop = tx_line;
      got_cnt = got_cnt + 8'h01;
   end
endmodule
`default_nettype wire
